// ==== muldiv_defines.vh ====
// Constants for the wide multiply/divide unit: register offsets, control bit
// positions, reset values and the cycle count of each operation.
// Assumes the register port carries 8-bit addresses and 8-bit data.
`ifndef MULDIV_DEFINES_VH
`define MULDIV_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define EXT_ACC2_ADDR       8'hce
`define EXT_ACC3_ADDR       8'hcf
`define EXT_ACC_ADDR        8'he6
`define EXT_B_ADDR          8'he7
`define MISC_CTRL2_ADDR     8'hf7

// ----------------------------------------------------------------------------
// Field positions in misc_control_2
// ----------------------------------------------------------------------------
`define WIDE_MODE_BIT       0
`define LONG_DIVIDE_BIT     3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define EXT_REG_RESET       8'h00
`define MISC_CTRL2_RESET    8'h00

// ----------------------------------------------------------------------------
// Cycle counts, one iteration per system clock
// ----------------------------------------------------------------------------
`define CLASSIC_CYCLES      6'h08
`define WIDE_MUL_CYCLES     6'h10
`define WIDE_DIV_CYCLES     6'h10
`define LONG_DIV_CYCLES     6'h20

`endif

// ==== muldiv_step.v ====
// One iteration of the shift-and-add multiplier or restoring divider.
// Purely combinational; the caller holds the working and shift registers.
`timescale 1ns/1ps

module muldiv_step #(
    parameter SHIFT_W = 32,
    parameter OPER_W  = 16
) (
    // Operation select: high for divide, low for multiply
    input  wire                 do_divide,
    // Current state
    input  wire [SHIFT_W-1:0]   work_in,
    input  wire [SHIFT_W-1:0]   shift_in,
    // Multiplicand or divisor
    input  wire [OPER_W-1:0]    operand,
    // Next state
    output reg  [SHIFT_W-1:0]   work_out,
    output reg  [SHIFT_W-1:0]   shift_out
);

    reg [OPER_W:0]   trial;
    reg [OPER_W+1:0] diff;
    reg              fits;

    always @*
    begin
        trial     = {work_in[OPER_W-1:0], shift_in[SHIFT_W-1]};
        diff      = {1'b0, trial} - {2'b00, operand};
        fits      = ~diff[OPER_W+1];
        work_out  = {SHIFT_W{1'b0}};
        shift_out = {shift_in[SHIFT_W-2:0], 1'b0};
        if (do_divide)
        begin
            // Restoring divide: the operand is subtracted only where it fits
            if (fits)
                work_out[OPER_W:0] = diff[OPER_W:0];
            else
                work_out[OPER_W:0] = trial;
            shift_out[0] = fits;
        end
        else
        begin
            // MSB-first multiply: double the partial product, then add
            work_out = {work_in[SHIFT_W-2:0], 1'b0};
            if (shift_in[SHIFT_W-1])
                work_out = work_out + {{(SHIFT_W-OPER_W){1'b0}}, operand};
        end
    end

endmodule // muldiv_step

// ==== wide_multiply_divide_unit.v ====
// Multiply/divide datapath serving the core's multiply and divide instructions,
// with its four extension registers and the mode control register.
// Assumes the core holds the accumulator and B, passes them in with a start
// pulse, and takes the results back on the done pulse.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "muldiv_defines.vh"

// How it works
// (RL1) Both mode bits clear: classic 8x8 multiply, 8/8 divide on accumulator and B.
// (RL2) Wide multiply: operands ext_acc:acc, ext_b:B; product ext_b,B,acc,ext_acc.
// (RL3) Wide multiply sets overflow when product upper bytes ext_b or B nonzero.
// (RL4) Wide 16x16 multiply finishes in exactly 16 clocks.
// (RL5) Wide divide: ext_acc:acc by ext_b:B; quotient acc:ext_acc, remainder B:ext_b.
// (RL6) Wide 16/16 divide finishes in exactly 16 clocks.
// (RL7) Both bits set: 32-bit dividend divided by ext_b:B, quotient over four bytes.
// (RL8) Long 32/16 divide finishes in exactly 32 clocks.
// (RL9) Long-divide bit matters only with wide mode set; selects 16/16 or 32/16.
// (RL10) Same multiply and divide requests in all modes; width from mode bits only.
// (RL11) Four read/write 8-bit extension registers, reset to zero.
// (RL12) Wide and long divides set overflow when divisor ext_b:B is zero.
module wide_multiply_divide_unit (
    // Clock and reset
    input  wire         core_clk,
    input  wire         rst,
    // Register port
    input  wire [7:0]   reg_addr,
    input  wire [7:0]   reg_wdata,
    input  wire         reg_wr,
    input  wire         reg_rd,
    output reg  [7:0]   reg_rdata_q,
    // Instruction requests from the core
    input  wire         mul_start,
    input  wire         div_start,
    input  wire [7:0]   acc_in,
    input  wire [7:0]   b_in,
    // Results back to the core
    output reg  [7:0]   acc_res_q,
    output reg  [7:0]   b_res_q,
    output reg          overflow_flag_q,
    output reg          done_q,
    output reg          busy_q,
    // Mode bits for the rest of the core
    output reg          wide_mode_bit_q,
    output reg          long_divide_bit_q
);

    // ------------------------------------------------------------------------
    // Operation kinds and states
    // ------------------------------------------------------------------------
    localparam ST_IDLE      = 1'b0;
    localparam ST_RUN       = 1'b1;

    localparam OP_CLASSIC   = 2'b00;
    localparam OP_WIDE      = 2'b01;
    localparam OP_LONG      = 2'b10;

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg         state_q;
    reg         state_d;
    reg [1:0]   kind_q;
    reg [1:0]   kind_d;
    reg         is_div_q;
    reg         is_div_d;
    reg [5:0]   cnt_q;
    reg [5:0]   cnt_d;
    reg [31:0]  work_q;
    reg [31:0]  work_d;
    reg [31:0]  shift_q;
    reg [31:0]  shift_d;
    reg [15:0]  oper_q;
    reg [15:0]  oper_d;

    reg [7:0]   ext_acc_q;
    reg [7:0]   ext_acc_d;
    reg [7:0]   ext_acc2_q;
    reg [7:0]   ext_acc2_d;
    reg [7:0]   ext_acc3_q;
    reg [7:0]   ext_acc3_d;
    reg [7:0]   ext_b_q;
    reg [7:0]   ext_b_d;
    reg         wide_mode_d;
    reg         long_div_d;

    reg [7:0]   acc_res_d;
    reg [7:0]   b_res_d;
    reg         ov_d;
    reg         done_d;
    reg         busy_d;
    reg [7:0]   rdata_d;

    wire [31:0] step_work;
    wire [31:0] step_shift;
    wire        start_any;
    wire        last_step;
    wire [15:0] quot_lo;
    wire [15:0] rem16;
    wire [7:0]  ctrl2_reset;

    // ------------------------------------------------------------------------
    // Iteration datapath
    // ------------------------------------------------------------------------
    muldiv_step #(
        .SHIFT_W    (32),
        .OPER_W     (16)
    ) u_step (
        .do_divide  (is_div_q),
        .work_in    (work_q),
        .shift_in   (shift_q),
        .operand    (oper_q),
        .work_out   (step_work),
        .shift_out  (step_shift)
    );

    assign start_any = mul_start | div_start;
    assign last_step = (cnt_q == 6'h01);
    assign quot_lo   = step_shift[15:0];
    assign rem16     = step_work[15:0];
    // Held as a byte so that each mode bit can be picked out by position
    assign ctrl2_reset = `MISC_CTRL2_RESET;

    // ------------------------------------------------------------------------
    // Control, datapath and register writes
    // ------------------------------------------------------------------------
    always @*
    begin
        state_d     = state_q;
        kind_d      = kind_q;
        is_div_d    = is_div_q;
        cnt_d       = cnt_q;
        work_d      = work_q;
        shift_d     = shift_q;
        oper_d      = oper_q;
        ext_acc_d   = ext_acc_q;
        ext_acc2_d  = ext_acc2_q;
        ext_acc3_d  = ext_acc3_q;
        ext_b_d     = ext_b_q;
        wide_mode_d = wide_mode_bit_q;
        long_div_d  = long_divide_bit_q;
        acc_res_d   = acc_res_q;
        b_res_d     = b_res_q;
        ov_d        = overflow_flag_q;
        done_d      = 1'b0;
        busy_d      = busy_q;

        // Software writes come first so that a finishing operation, which
        // is assigned later, wins over a write in the same cycle
        if (reg_wr)
        begin
            if (reg_addr == `EXT_ACC_ADDR)
                ext_acc_d = reg_wdata; // RL11
            else if (reg_addr == `EXT_ACC2_ADDR)
                ext_acc2_d = reg_wdata; // RL11
            else if (reg_addr == `EXT_ACC3_ADDR)
                ext_acc3_d = reg_wdata; // RL11
            else if (reg_addr == `EXT_B_ADDR)
                ext_b_d = reg_wdata; // RL11
            else if (reg_addr == `MISC_CTRL2_ADDR)
            begin
                wide_mode_d = reg_wdata[`WIDE_MODE_BIT];
                long_div_d  = reg_wdata[`LONG_DIVIDE_BIT];
            end
        end

        case (state_q)
            ST_IDLE:
            begin
                // A start while busy is never seen here, so it is dropped
                if (start_any)
                begin
                    state_d  = ST_RUN;
                    busy_d   = 1'b1;
                    is_div_d = ~mul_start;
                    work_d   = 32'h0000_0000;
                    // Width comes only from the mode bits, never the request
                    if (!wide_mode_bit_q) // RL10
                    begin
                        kind_d  = OP_CLASSIC; // RL1
                        cnt_d   = `CLASSIC_CYCLES;
                        shift_d = {acc_in, 24'h00_0000};
                        oper_d  = {8'h00, b_in};
                    end
                    else if (mul_start || !long_divide_bit_q) // RL9
                    begin
                        kind_d  = OP_WIDE;
                        cnt_d   = mul_start ? `WIDE_MUL_CYCLES : `WIDE_DIV_CYCLES; // RL4 RL6
                        shift_d = {ext_acc_q, acc_in, 16'h0000}; // RL2 RL5
                        oper_d  = {ext_b_q, b_in};
                    end
                    else
                    begin
                        kind_d  = OP_LONG;
                        cnt_d   = `LONG_DIV_CYCLES; // RL8
                        shift_d = {ext_acc3_q, ext_acc2_q, ext_acc_q, acc_in}; // RL7
                        oper_d  = {ext_b_q, b_in};
                    end
                end
            end

            ST_RUN:
            begin
                work_d  = step_work;
                shift_d = step_shift;
                cnt_d   = cnt_q - 6'h01;
                if (last_step)
                begin
                    state_d = ST_IDLE;
                    busy_d  = 1'b0;
                    done_d  = 1'b1;
                    case (kind_q)
                        OP_CLASSIC:
                        begin
                            // Classic overflow: product above 255 or divide by zero
                            if (is_div_q)
                            begin
                                acc_res_d = quot_lo[7:0]; // RL1
                                b_res_d   = rem16[7:0];
                                ov_d      = (oper_q[7:0] == 8'h00);
                            end
                            else
                            begin
                                acc_res_d = step_work[7:0]; // RL1
                                b_res_d   = step_work[15:8];
                                ov_d      = (step_work[15:8] != 8'h00);
                            end
                        end
                        OP_WIDE:
                        begin
                            if (is_div_q)
                            begin
                                acc_res_d = quot_lo[15:8]; // RL5
                                ext_acc_d = quot_lo[7:0];
                                b_res_d   = rem16[15:8];
                                ext_b_d   = rem16[7:0];
                                ov_d      = (oper_q == 16'h0000); // RL12
                            end
                            else
                            begin
                                ext_b_d   = step_work[31:24]; // RL2
                                b_res_d   = step_work[23:16];
                                acc_res_d = step_work[15:8];
                                ext_acc_d = step_work[7:0];
                                ov_d      = (step_work[31:16] != 16'h0000); // RL3
                            end
                        end
                        default:
                        begin
                            acc_res_d  = step_shift[31:24]; // RL7
                            ext_acc_d  = step_shift[23:16];
                            ext_acc2_d = step_shift[15:8];
                            ext_acc3_d = step_shift[7:0];
                            b_res_d    = rem16[15:8];
                            ext_b_d    = rem16[7:0];
                            ov_d       = (oper_q == 16'h0000); // RL12
                        end
                    endcase
                end
            end

            default:
            begin
                state_d = ST_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------------------
    always @*
    begin
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == `EXT_ACC_ADDR)
                rdata_d = ext_acc_q; // RL11
            else if (reg_addr == `EXT_ACC2_ADDR)
                rdata_d = ext_acc2_q;
            else if (reg_addr == `EXT_ACC3_ADDR)
                rdata_d = ext_acc3_q;
            else if (reg_addr == `EXT_B_ADDR)
                rdata_d = ext_b_q;
            else if (reg_addr == `MISC_CTRL2_ADDR)
            begin
                // Other bits of this register belong to other blocks
                rdata_d[`WIDE_MODE_BIT]   = wide_mode_bit_q;
                rdata_d[`LONG_DIVIDE_BIT] = long_divide_bit_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            state_q           <= ST_IDLE;
            kind_q            <= OP_CLASSIC;
            is_div_q          <= 1'b0;
            cnt_q             <= 6'h00;
            work_q            <= 32'h0000_0000;
            shift_q           <= 32'h0000_0000;
            oper_q            <= 16'h0000;
            ext_acc_q         <= `EXT_REG_RESET; // RL11
            ext_acc2_q        <= `EXT_REG_RESET;
            ext_acc3_q        <= `EXT_REG_RESET;
            ext_b_q           <= `EXT_REG_RESET;
            wide_mode_bit_q   <= ctrl2_reset[`WIDE_MODE_BIT];
            long_divide_bit_q <= ctrl2_reset[`LONG_DIVIDE_BIT];
            acc_res_q         <= 8'h00;
            b_res_q           <= 8'h00;
            overflow_flag_q   <= 1'b0;
            done_q            <= 1'b0;
            busy_q            <= 1'b0;
            reg_rdata_q       <= 8'h00;
        end
        else
        begin
            state_q           <= state_d;
            kind_q            <= kind_d;
            is_div_q          <= is_div_d;
            cnt_q             <= cnt_d;
            work_q            <= work_d;
            shift_q           <= shift_d;
            oper_q            <= oper_d;
            ext_acc_q         <= ext_acc_d;
            ext_acc2_q        <= ext_acc2_d;
            ext_acc3_q        <= ext_acc3_d;
            ext_b_q           <= ext_b_d;
            wide_mode_bit_q   <= wide_mode_d;
            long_divide_bit_q <= long_div_d;
            acc_res_q         <= acc_res_d;
            b_res_q           <= b_res_d;
            overflow_flag_q   <= ov_d;
            done_q            <= done_d;
            busy_q            <= busy_d;
            reg_rdata_q       <= rdata_d;
        end
    end

endmodule // wide_multiply_divide_unit

// ==== muldiv_properties.sv ====
// Concurrent checks on the ports of the wide multiply/divide unit.
// Assumes one clock and a synchronous, active-high reset.
`timescale 1ns/1ps

module muldiv_properties (
    // Clock and reset
    input wire       core_clk,
    input wire       rst,
    // Register port
    input wire       reg_rd,
    input wire [7:0] reg_rdata_q,
    // Operation port
    input wire       mul_start,
    input wire       div_start,
    input wire [7:0] b_in,
    input wire [7:0] b_res_q,
    input wire       overflow_flag_q,
    input wire       done_q,
    input wire       busy_q,
    input wire       wide_mode_bit_q,
    input wire       long_divide_bit_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------------
    // Accepted requests
    // ------------------------------------------------------------------------
    // A start while busy is dropped, and multiply wins over divide
    wire take     = (mul_start || div_start) && !busy_q;
    wire take_mul = take && mul_start;
    wire take_div = take && !mul_start;

    sequence s_classic_run;
        busy_q [*8] ##1 (done_q && !busy_q);
    endsequence
    sequence s_wide_mul;
        take_mul && wide_mode_bit_q;
    endsequence

    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    a_classic_len: assert property (take && !wide_mode_bit_q |=> s_classic_run)
        else $error("classic operation not done after 8 clocks");
    a_mode_gate: assert property (
        take_div && !wide_mode_bit_q && long_divide_bit_q |=> s_classic_run)
        else $error("long divide bit acted without wide mode");
    a_wide_mul_len: assert property (s_wide_mul |-> ##16 !done_q ##1 done_q)
        else $error("wide multiply not done after exactly 16 clocks");
    a_wide_div_len: assert property (
        take_div && wide_mode_bit_q && !long_divide_bit_q |-> ##16 !done_q ##1 done_q)
        else $error("wide divide not done after exactly 16 clocks");
    a_long_div_len: assert property (
        take_div && wide_mode_bit_q && long_divide_bit_q |-> ##32 !done_q ##1 done_q)
        else $error("long divide not done after exactly 32 clocks");
    a_wide_mul_ovf: assert property (
        s_wide_mul ##17 (done_q && b_res_q != 8'h00) |-> overflow_flag_q)
        else $error("wide multiply upper byte set without overflow");
    a_div_nz_ovf: assert property (
        take_div && wide_mode_bit_q && !long_divide_bit_q && b_in != 8'h00
        |-> ##17 !overflow_flag_q)
        else $error("overflow with a nonzero divisor");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
        else $error("read data shown without a read");
endmodule // muldiv_properties

bind wide_multiply_divide_unit muldiv_properties u_muldiv_properties (
    .core_clk(core_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .mul_start(mul_start), .div_start(div_start), .b_in(b_in), .b_res_q(b_res_q),
    .overflow_flag_q(overflow_flag_q), .done_q(done_q), .busy_q(busy_q),
    .wide_mode_bit_q(wide_mode_bit_q), .long_divide_bit_q(long_divide_bit_q));

// ==== core_model.sv ====
// Behavioural core that issues multiply and divide requests and times them.
// Assumes the unit answers with a one-cycle done pulse within 64 clocks.
`timescale 1ns/1ps

module core_model (
    // Clock
    input  wire         core_clk,
    // Requests to the unit
    output logic        mul_start,
    output logic        div_start,
    output logic [7:0]  acc_in,
    output logic [7:0]  b_in,
    // Answer from the unit
    input  wire         done_q
);
    int cycles;

    initial
    begin
        mul_start = 1'b0;
        div_start = 1'b0;
        acc_in    = 8'h00;
        b_in      = 8'h00;
    end

    // ------------------------------------------------------------------------
    // One instruction; poke sends a divide request while the unit is busy
    // ------------------------------------------------------------------------
    task automatic run(input bit is_div, input logic [7:0] a, input logic [7:0] b,
                       input bit poke, input int gap);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        mul_start <= !is_div;
        div_start <= is_div;
        acc_in    <= a;
        b_in      <= b;
        @(posedge core_clk);
        mul_start <= 1'b0;
        div_start <= 1'b0;
        // Operands are not held after the start, so show something else
        acc_in    <= ~a;
        b_in      <= ~b;
        // Edges from the one that takes the start to the one that raises done
        cycles = 0;
        #1;
        while (!done_q && cycles < 64)
        begin
            @(posedge core_clk);
            div_start <= poke && (cycles == 3);
            cycles++;
            #1;
        end
    endtask
endmodule // core_model

// ==== wide_multiply_divide_unit_tb.sv ====
// Self-checking bench for the multiply/divide unit: registers through the
// strobe port, instructions through the core model, expectations made here.
`timescale 1ns/1ps
`include "muldiv_defines.vh"

module wide_multiply_divide_unit_tb;
    logic       core_clk  = 1'b0;
    logic       rst       = 1'b1;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    wire  [7:0] reg_rdata_q, acc_in, b_in, acc_res_q, b_res_q;
    wire        mul_start, div_start, overflow_flag_q, done_q, busy_q, wide_q, long_q;
    int         miscompares = 0;
    int         compares    = 0;
    // Mode register, one unmapped place, then the extension registers
    logic [7:0] reg_map[6] = '{`MISC_CTRL2_ADDR, 8'h10, `EXT_ACC_ADDR, `EXT_B_ADDR,
                               `EXT_ACC2_ADDR, `EXT_ACC3_ADDR};

    always #10 core_clk = ~core_clk;

    core_model u_core_model (.core_clk(core_clk), .mul_start(mul_start),
        .div_start(div_start), .acc_in(acc_in), .b_in(b_in), .done_q(done_q));

    wide_multiply_divide_unit u_wide_multiply_divide_unit (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .mul_start(mul_start), .div_start(div_start),
        .acc_in(acc_in), .b_in(b_in), .acc_res_q(acc_res_q), .b_res_q(b_res_q),
        .overflow_flag_q(overflow_flag_q), .done_q(done_q), .busy_q(busy_q),
        .wide_mode_bit_q(wide_q), .long_divide_bit_q(long_q));

    // ------------------------------------------------------------------------
    // Compare, bus and closing tasks
    // ------------------------------------------------------------------------
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        compares++;
        if (got != exp)
        begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        check_byte(reg_rdata_q, exp);
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // One instruction in a given mode; mode[0] wide, mode[1] long divide
    // ------------------------------------------------------------------------
    task automatic op(input bit is_div, input logic [1:0] mode, input logic [31:0] dvd,
                      input logic [15:0] dvs, input bit poke);
        logic [7:0]  x[6];
        logic [31:0] p;
        logic [31:0] q;
        logic [15:0] r;
        logic        ov;
        int          n;
        x = '{8'h00, 8'h00, dvd[15:8], dvs[15:8], dvd[23:16], dvd[31:24]};
        reg_write(`MISC_CTRL2_ADDR, {4'h0, mode[1], 2'b00, mode[0]});
        for (int i = 2; i < 6; i++) reg_write(reg_map[i], x[i]);
        u_core_model.run(is_div, dvd[7:0], dvs[7:0], poke, 0);
        if (!mode[0])
        begin
            n = 8;
            p = dvd[7:0] * dvs[7:0];
            q = dvd[7:0] / dvs[7:0];
            r = dvd[7:0] % dvs[7:0];
            ov = is_div ? (dvs[7:0] == 8'h00) : (p[15:8] != 8'h00);
            x[0] = is_div ? q[7:0] : p[7:0];
            x[1] = is_div ? r[7:0] : p[15:8];
        end
        else if (!is_div)
        begin
            n = 16;
            p = dvd[15:0] * dvs;
            ov = (p[31:16] != 16'h0000);
            {x[3], x[1], x[0], x[2]} = p;
        end
        else
        begin
            n = mode[1] ? 32 : 16;
            q = mode[1] ? dvd / dvs : dvd[15:0] / dvs;
            r = 16'(mode[1] ? dvd % dvs : dvd[15:0] % dvs);
            ov = (dvs == 16'h0000);
            {x[1], x[3]} = r;
            if (mode[1])
                {x[0], x[2], x[4], x[5]} = q;
            else
                {x[0], x[2]} = q[15:0];
        end
        if (u_core_model.cycles >= 64)
        begin
            miscompares++;
            end_of_test();
        end
        check_count(u_core_model.cycles, n);
        check_byte({7'h00, overflow_flag_q}, {7'h00, ov});
        // Results of a zero divide are left undefined
        if (!ov || !is_div)
        begin
            check_byte(acc_res_q, x[0]);
            check_byte(b_res_q, x[1]);
            for (int i = 2; i < 6; i++) reg_read(reg_map[i], x[i]);
        end
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) reg_read(reg_map[i], 8'h00);
        reg_write(`MISC_CTRL2_ADDR, 8'hff);
        reg_read(`MISC_CTRL2_ADDR, 8'h09);
        check_byte({6'h00, long_q, wide_q}, 8'h03);
        reg_write(8'h10, 8'h5a);
        reg_read(8'h10, 8'h00);
        op(1'b0, 2'b00, 32'h0000_00c8, 16'h0003, 1'b0);
        op(1'b1, 2'b10, 32'h0000_00c8, 16'h0007, 1'b1);
        op(1'b1, 2'b00, 32'h0000_0042, 16'h0000, 1'b0);
        op(1'b0, 2'b01, 32'h0000_1256, 16'h3478, 1'b1);
        op(1'b0, 2'b11, 32'h0000_0010, 16'h0020, 1'b0);
        op(1'b1, 2'b01, 32'h0000_ab12, 16'h0034, 1'b1);
        op(1'b1, 2'b01, 32'h0000_1234, 16'h0000, 1'b0);
        op(1'b1, 2'b11, 32'h89ab_cdef, 16'h1234, 1'b0);
        op(1'b1, 2'b11, 32'h0102_0304, 16'h0000, 1'b0);
        end_of_test();
    end
endmodule // wide_multiply_divide_unit_tb
